// ==== src/uart_modem_handshake_control.v ====
// modem handshake control of one uart channel with apb register access
//
// Implementation choice: the APB interface to the registers.
`include "modem_hs_map.vh"

// Behaviour
// (RULE1) modem control bit 13 reads back the live request-to-send pin level.
// (RULE2) modem control bit 9 chooses request-to-send active high or low.
// (RULE3) on the channel without modem support both registers read zero.
// (RULE4) modem control resets to 0x200, request-to-send active high.
// (RULE5) modem status bit 8 chooses clear-to-send active high or low.
// (RULE6) modem status bit 4 reads back the live clear-to-send pin level.
// (RULE7) any clear-to-send level change sets the change flag, bit 0.
// (RULE8) change flag with handshake interrupt enable raises modem interrupt.
// (RULE9) writing one clears the change flag; writing zero keeps it.
// (RULE10) modem status resets to zero, flag clear, level select zero.
// (RULE11) request-to-send output follows bit 1 with the chosen polarity.
module uart_modem_handshake_control #(
  parameter MODEM_PRESENT = 1
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  input  wire        handshake_interrupt_enable,
  input  wire        clear_to_send_n_pin,
  output reg         request_to_send_pin,
  output wire        clear_to_send_active,
  output wire        modem_irq,
  output wire        irq
);
  localparam HAS = (MODEM_PRESENT != 0);

  reg        rts_ctrl;
  reg        request_to_send_active_high;
  reg        clear_to_send_active_high;
  reg        clear_to_send_change_flag;
  reg        int_status;
  reg        int_mask;
  reg        next_rts_pin;
  wire       cts_sync;
  wire       cts_changed;
  wire       request_to_send_pin_level;
  wire       clear_to_send_pin_level;
  wire       wr;
  wire       rd;
  wire       lane0;
  wire       lane1;
  wire       mapped;
  wire       hit_mcr;
  wire       hit_msr;
  wire       hit_ist;
  wire       hit_imk;
  wire [31:0] mcr_value;
  wire [31:0] msr_value;

  // apb decode; zero wait states
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & ~penable & ~pwrite;
  assign lane0   = pstrb[0];
  assign lane1   = pstrb[1];
  assign hit_mcr = (paddr == `MODEM_CONTROL_OFFSET);
  assign hit_msr = (paddr == `MODEM_STATUS_OFFSET);
  assign hit_ist = (paddr == `INT_STATUS_OFFSET);
  assign hit_imk = (paddr == `INT_MASK_OFFSET);
  assign mapped  = hit_mcr | hit_msr | hit_ist | hit_imk;
  assign pready  = 1'b1;
  // unmapped addresses answer with an error, reads zero
  assign pslverr = psel & penable & ~mapped;

  // pin is asynchronous to pclk
  pin_sync #(
    .RESET_VALUE (1'b0)
  ) u_cts_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (clear_to_send_n_pin),
    .sync_out (cts_sync)
  );

  change_detect u_cts_change (
    .pclk     (pclk),
    .presetn  (presetn),
    .level_in (cts_sync),
    .armed    (HAS[0]),
    .changed  (cts_changed)
  );

  assign clear_to_send_pin_level   = cts_sync & HAS[0]; // RULE6
  assign request_to_send_pin_level = request_to_send_pin & HAS[0]; // RULE1
  // active when the pin sits at the selected level
  assign clear_to_send_active = HAS[0] &
    (cts_sync == clear_to_send_active_high); // RULE5

  // control bits; absent channel keeps them at reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_ctrl                    <= 1'b0; // RULE4
      request_to_send_active_high <= 1'b1; // RULE4
      clear_to_send_active_high   <= 1'b0; // RULE10
      int_mask                    <= 1'b0;
    end else if (wr && HAS) begin
      if (hit_mcr && lane0)
        rts_ctrl <= pwdata[`MCR_RTS_BIT];
      if (hit_mcr && lane1)
        request_to_send_active_high <= pwdata[`MCR_RTS_LEVEL_BIT]; // RULE2
      if (hit_msr && lane1)
        clear_to_send_active_high <= pwdata[`MSR_CTS_LEVEL_BIT]; // RULE5
      if (hit_imk && lane0)
        int_mask <= pwdata[`INT_CTS_CHANGE_BIT];
    end
  end

  // sticky flags: a set in the clear cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_to_send_change_flag <= 1'b0; // RULE10
      int_status                <= 1'b0;
    end else begin
      if (cts_changed)
        clear_to_send_change_flag <= 1'b1; // RULE7
      else if (wr && hit_msr && lane0 && pwdata[`MSR_CHANGE_BIT])
        clear_to_send_change_flag <= 1'b0; // RULE9
      if (cts_changed)
        int_status <= 1'b1;
      else if (wr && hit_ist && lane0 && pwdata[`INT_CTS_CHANGE_BIT])
        int_status <= 1'b0;
    end
  end

  // polarity: active high drives bit as is, active low inverts it
  always @* begin
    next_rts_pin = rts_ctrl ^ ~request_to_send_active_high; // RULE11
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      request_to_send_pin <= 1'b0;
    else
      request_to_send_pin <= next_rts_pin & HAS[0]; // RULE11
  end

  assign modem_irq = clear_to_send_change_flag &
                     handshake_interrupt_enable; // RULE8
  assign irq       = int_status & int_mask;

  assign mcr_value = {18'h00000, request_to_send_pin_level, 3'h0,
                      request_to_send_active_high, 7'h00, rts_ctrl, 1'b0};
  assign msr_value = {23'h000000, clear_to_send_active_high, 3'h0,
                      clear_to_send_pin_level, 3'h0,
                      clear_to_send_change_flag};

  // read data registered in the setup cycle, held through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd) begin
      if (!HAS)
        prdata <= 32'h0000_0000; // RULE3
      else if (hit_mcr)
        prdata <= mcr_value; // RULE1
      else if (hit_msr)
        prdata <= msr_value; // RULE6
      else if (hit_ist)
        prdata <= {31'h00000000, int_status};
      else if (hit_imk)
        prdata <= {31'h00000000, int_mask};
      else
        prdata <= 32'h0000_0000;
    end
  end
endmodule // uart_modem_handshake_control

// ==== src/modem_hs_map.vh ====
// register offsets, field positions and reset values of the handshake block
`ifndef MODEM_HS_MAP_VH
`define MODEM_HS_MAP_VH
`define MODEM_CONTROL_OFFSET     12'h010
`define MODEM_STATUS_OFFSET      12'h014
`define INT_STATUS_OFFSET        12'h020
`define INT_MASK_OFFSET          12'h024
`define MODEM_CONTROL_RESET      32'h0000_0200
`define MODEM_STATUS_RESET       32'h0000_0000
`define MCR_RTS_BIT              1
`define MCR_RTS_LEVEL_BIT        9
`define MCR_RTS_PIN_BIT          13
`define MSR_CHANGE_BIT           0
`define MSR_CTS_PIN_BIT          4
`define MSR_CTS_LEVEL_BIT        8
`define INT_CTS_CHANGE_BIT       0
`endif

// ==== src/pin_sync.v ====
// two-flop synchroniser for an asynchronous input level
module pin_sync #(
  parameter RESET_VALUE = 1'b0
) (
  input  wire pclk,
  input  wire presetn,
  input  wire async_in,
  output reg  sync_out
);
  reg meta;

  // first flop feeds only the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // pin_sync

// ==== src/change_detect.v ====
// edge detector on a synchronised level, either direction
module change_detect (
  input  wire pclk,
  input  wire presetn,
  input  wire level_in,
  input  wire armed,
  output wire changed
);
  reg       last;
  reg [2:0] seen;

  // history is trusted only once the synchroniser holds a real pin
  // sample; a pin resting high through reset would look like a change
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last <= 1'b0;
      seen <= 3'h0;
    end else begin
      last <= level_in;
      seen <= {seen[1:0], 1'b1};
    end
  end

  assign changed = armed & seen[2] & (last != level_in);
endmodule // change_detect

// ==== tb/hs_checker.sv ====
// pin-level assertions for the modem handshake block
module hs_checker #(
  parameter MODEM_PRESENT = 1
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        handshake_interrupt_enable,
  input wire logic        clear_to_send_n_pin,
  input wire logic        request_to_send_pin,
  input wire logic        modem_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // m gates the rules that only a channel with modem support keeps
  wire m  = MODEM_PRESENT != 0;
  wire wr = psel && penable && pwrite && pstrb[1:0] == 2'h3;
  wire rd = psel && !penable && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !m);
  rts_drive_a: assert property (wr && paddr == 12'h010 |-> ##2
    request_to_send_pin == ($past(pwdata[1], 2) ^ !$past(pwdata[9], 2)))
    else $error("request-to-send pin level wrong");
  rts_state_a: assert property (rd && paddr == 12'h010 |=>
    prdata[13] == $past(request_to_send_pin)) else $error("pin bit wrong");
  cts_state_a: assert property ($stable(clear_to_send_n_pin)[*6] ##0
    (rd && paddr == 12'h014) |=> prdata[4] == $past(clear_to_send_n_pin))
    else $error("clear-to-send state bit wrong");
  cts_change_a: assert property ($changed(clear_to_send_n_pin) &&
    handshake_interrupt_enable |-> ##[1:5] modem_irq) else $error("no flag");
  flag_clear_a: assert property ($stable(clear_to_send_n_pin)[*6] ##0
    (wr && paddr == 12'h014 && pwdata[0]) |=> !modem_irq)
    else $error("flag not cleared");
  flag_hold_a: assert property (modem_irq && wr && paddr == 12'h014 &&
    !pwdata[0] |=> modem_irq) else $error("flag lost on zero write");
  irq_gate_a: assert property (!handshake_interrupt_enable |->
    !modem_irq) else $error("modem interrupt while disabled");
  absent_zero_a: assert property (disable iff (!presetn)
    rd && !m |=> prdata == 32'h0) else $error("absent channel reads nonzero");
  cover property (wr && paddr == 12'h010);
  cover property ($rose(modem_irq));
  cover property ($fell(modem_irq));
endmodule // hs_checker

// ==== tb/flow_peer.sv ====
// remote peer: answers the request-to-send pin on its clear-to-send line
module flow_peer (
  input  wire logic pclk,
  input  wire logic request_to_send_pin,
  output logic      clear_to_send_n_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // low at reset so the status register shows its reset image
  initial clear_to_send_n_pin = 1'b0;
  // mirror the request after lag cycles; a slow peer takes long
  task automatic answer(input int lag);
    repeat (lag) @(posedge pclk);
    clear_to_send_n_pin <= request_to_send_pin;
  endtask
endmodule // flow_peer

// ==== tb/tb_uart_modem_handshake_control.sv ====
// bench for the modem handshake block with a flow-control peer
module tb_uart_modem_handshake_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, pready, pslverr, err, request_to_send_pin;
  logic        clear_to_send_n_pin, clear_to_send_active, modem_irq, irq;
  logic        presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        handshake_interrupt_enable = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, prdata_n, rd;
  logic [3:0]  pstrb = 4'hf;
  int          fails = 0, comparisons = 0, cycles = 0;
  uart_modem_handshake_control dut_u (.*);
  uart_modem_handshake_control #(.MODEM_PRESENT(0)) dut_n (.*, .pready(),
    .pslverr(), .prdata(prdata_n), .request_to_send_pin(),
    .clear_to_send_active(), .modem_irq(), .irq());
  flow_peer peer_u (.*);
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  // the whole run needs under a hundred cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; data taken at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic t_reset();
    apb(0, 12'h010, 0);
    chk(rd, 32'h0000_0200);
    chk(prdata_n, 32'h0);
    apb(0, 12'h014, 0);
    chk(rd, 32'h0);
    apb(0, 12'h030, 0);
    chk(err, 1'b1);
  endtask
  // every control and polarity pair on the pin and its readback
  task automatic t_rts();
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h010, {22'h0, i[1], 7'h0, i[0], 1'b0});
      repeat (2) @(posedge pclk);
      chk(request_to_send_pin, i[0] ^ !i[1]);
      apb(0, 12'h010, 0);
      chk(rd, {18'h0, i[0] ^ !i[1], 3'h0, i[1], 7'h0, i[0], 1'b0});
    end
  endtask
  // slow peer answer sets the flag; zero write keeps, one write clears
  task automatic t_cts();
    handshake_interrupt_enable <= 1;
    apb(1, 12'h024, 1);
    apb(1, 12'h010, 32'h202);
    peer_u.answer(4);
    repeat (6) @(posedge pclk);
    chk({modem_irq, irq}, 2'b11);
    apb(1, 12'h014, 0);
    apb(0, 12'h014, 0);
    chk(rd, 32'h11);
    handshake_interrupt_enable <= 0;
    apb(1, 12'h024, 0);
    @(posedge pclk);
    chk({modem_irq, irq}, 2'b00);
    handshake_interrupt_enable <= 1;
    apb(1, 12'h014, 1);
    @(posedge pclk);
    chk(modem_irq, 1'b0);
    apb(1, 12'h020, 1);
    apb(1, 12'h014, 32'h100);
    apb(0, 12'h014, 0);
    chk(rd, 32'h110);
    chk(prdata_n, 32'h0);
    chk(clear_to_send_active, 1'b1);
    // request dropped: the peer follows low, a falling change flags too
    apb(1, 12'h010, 32'h200);
    peer_u.answer(2);
    repeat (6) @(posedge pclk);
    chk({modem_irq, irq}, 2'b10);
    apb(0, 12'h014, 0);
    chk(rd, 32'h101);
    chk(clear_to_send_active, 1'b0);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_rts();
    t_cts();
    stop_test();
  end
endmodule // tb_uart_modem_handshake_control
bind uart_modem_handshake_control hs_checker #(
  .MODEM_PRESENT(MODEM_PRESENT)) chk_u (.*);
